// ==== ccr_regbank.sv ====
// Serial-port register bank front: port config, identity, commit and multipin modes.
`timescale 1ns/100ps
module ccr_regbank #(
	parameter logic [3:0] CHIP_KIND = 4'h1, // Arbitrary value.
	parameter logic [11:0] PART_SERIAL = 12'h123, // Arbitrary value.
	parameter logic [7:0] PART_VERSION = 8'h01, // Arbitrary value.
	parameter logic [7:0] PORT_VERSION = 8'h00,
	parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value.
	parameter ccr_pkg::ccr_wd_class_t MULTIPIN_WD = ccr_pkg::CCR_WD_NONE
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Byte register port from the serial port engine.
	input wire logic [ccr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ccr_pkg::DATA_W-1:0] reg_wdata,
	output logic [ccr_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// Serial port controls.
	output logic lsb_first,
	output logic addr_ascend,
	output logic keep_map_reset,
	// Commit and multipin drive modes.
	output logic commit_pulse,
	output logic [7:0] multipin_drive_modes,
	// Lock report and write-detect effects.
	input wire logic lock_raw,
	output logic lock_report,
	output logic [ccr_pkg::WD_N-1:0] wd_hold,
	output logic [ccr_pkg::WD_N-1:0] wd_restart
);
	import ccr_pkg::*;

	ccr_wd_if wd ();

	logic [7:0] cfg_a_q;
	logic [7:0] cfg_a_d;
	logic read_buf_q;
	logic keep_map_q;
	logic commit_q;
	logic commit_d;
	logic soft_q;
	logic [7:0] mp_buf_q;
	logic [7:0] mp_buf_d;
	logic [7:0] mp_act_q;
	logic [7:0] mp_act_d;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// Address decode.
	wire hit_cfg_a = reg_addr == ADDR_CFG_A;
	wire hit_cfg_b = reg_addr == ADDR_CFG_B;
	wire hit_commit = reg_addr == ADDR_COMMIT;
	wire hit_mp = reg_addr == ADDR_MULTIPIN;
	wire wr_cfg_a = reg_wr && hit_cfg_a;
	wire wr_cfg_b = reg_wr && hit_cfg_b;
	wire wr_commit = reg_wr && hit_commit && reg_wdata == COMMIT_CODE;
	wire wr_mp = reg_wr && hit_mp;

	// Either mirror copy of a control sets it; both copies then read back set, except the soft-reset pair, which clears one cycle later.
	wire soft_req = reg_wdata[CFGA_SOFT_HI] | reg_wdata[CFGA_SOFT_LO];
	wire lsb_req = reg_wdata[CFGA_LSB_HI] | reg_wdata[CFGA_LSB_LO];
	wire asc_req = reg_wdata[CFGA_ASC_HI] | reg_wdata[CFGA_ASC_LO];
	wire [7:0] cfg_a_mirror = {soft_req, lsb_req, asc_req, 2'b00, asc_req, lsb_req, soft_req};

	assign cfg_a_d = soft_q ? CFG_A_RST : (wr_cfg_a ? cfg_a_mirror : cfg_a_q);
	assign commit_d = soft_q ? 1'b0 : (wr_commit | (commit_q & 1'b0));
	assign mp_buf_d = soft_q ? MULTIPIN_RST : (wr_mp ? reg_wdata : mp_buf_q);
	assign mp_act_d = soft_q ? MULTIPIN_RST : (commit_q ? mp_buf_q : mp_act_q);

	// Read data: identity bytes are constants, unlisted or reserved addresses read zero.
	wire [7:0] mp_view = read_buf_q ? mp_buf_q : mp_act_q;
	wire [7:0] cfg_b_view = {2'b00, read_buf_q, keep_map_q, 4'h0};
	wire [7:0] rd_mux =
		hit_cfg_a ? cfg_a_q :
		hit_cfg_b ? cfg_b_view :
		(reg_addr == ADDR_CHIP_KIND) ? {4'h0, CHIP_KIND} :
		(reg_addr == ADDR_SERIAL_LO) ? {PART_SERIAL[3:0], 4'h0} :
		(reg_addr == ADDR_SERIAL_HI) ? PART_SERIAL[11:4] :
		(reg_addr == ADDR_VERSION) ? PART_VERSION :
		(reg_addr == ADDR_PORT_VER) ? PORT_VERSION :
		(reg_addr == ADDR_MAKER_LO) ? MAKER_CODE[7:0] :
		(reg_addr == ADDR_MAKER_HI) ? MAKER_CODE[15:8] :
		hit_commit ? {7'h00, commit_q} :
		hit_mp ? mp_view :
		READ_ZERO;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_a_q <= CFG_A_RST;
			soft_q <= 1'b0;
			commit_q <= 1'b0;
			mp_buf_q <= MULTIPIN_RST;
			mp_act_q <= MULTIPIN_RST;
		end else begin
			cfg_a_q <= cfg_a_d;
			soft_q <= wr_cfg_a & soft_req & ~soft_q;
			commit_q <= commit_d;
			mp_buf_q <= mp_buf_d;
			mp_act_q <= mp_act_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || soft_q) begin
			read_buf_q <= CFG_B_RST[CFGB_READ_BUF];
			keep_map_q <= CFG_B_RST[CFGB_KEEP_MAP];
		end else begin
			read_buf_q <= wr_cfg_b ? reg_wdata[CFGB_READ_BUF] : read_buf_q;
			keep_map_q <= wr_cfg_b & reg_wdata[CFGB_KEEP_MAP] & ~keep_map_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= READ_ZERO;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : rdata_q;
			rvalid_q <= reg_rd;
		end
	end

	// Write-detect: only the multipin register can carry a class here.
	assign wd.wr_pulse = wr_mp && (MULTIPIN_WD != CCR_WD_NONE);
	assign wd.wr_class = MULTIPIN_WD;
	assign wd.commit = commit_q;

	ccr_write_detect u_wd (
		.clk(clk),
		.rst_n(rst_n),
		.wd(wd)
	);

	// Unlock and lock-drop classes hold the reported lock low until a commit.
	assign lock_report = lock_raw & ~wd.hold[0] & ~wd.hold[2];

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign lsb_first = cfg_a_q[CFGA_LSB_LO];
	assign addr_ascend = cfg_a_q[CFGA_ASC_LO];
	assign keep_map_reset = keep_map_q;
	assign commit_pulse = commit_q;
	assign multipin_drive_modes = mp_act_q;
	assign wd_hold = wd.hold;
	assign wd_restart = wd.restart;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_commit_write;
		wr_commit && !soft_q && !wr_cfg_a;
	endsequence

	// A second commit right behind the first may set the bit again; otherwise it must drop.
	sequence s_commit_done;
		commit_q ##1 commit_q == $past(wr_commit && !soft_q);
	endsequence

	property p_unlisted_write_keeps;
		reg_wr && !hit_cfg_a && !hit_cfg_b && !hit_commit && !hit_mp && !soft_q
			|=> $stable(mp_buf_q) && $stable(cfg_a_q) && !commit_q;
	endproperty
	a_unlisted_write_keeps: assert property (p_unlisted_write_keeps) else $error("unlisted write changed state");

	property p_live_cfg_a;
		wr_cfg_a && !soft_q |=> lsb_first == $past(lsb_req) && addr_ascend == $past(asc_req);
	endproperty
	a_live_cfg_a: assert property (p_live_cfg_a) else $error("config A write not live");

	property p_ident_read;
		reg_rd && reg_addr == ADDR_MAKER_HI |=> reg_rvalid && reg_rdata == MAKER_CODE[15:8];
	endproperty
	a_ident_read: assert property (p_ident_read) else $error("identity byte wrong");

	property p_commit_autoclear;
		s_commit_write |=> s_commit_done;
	endproperty
	a_commit_autoclear: assert property (p_commit_autoclear) else $error("commit bit did not clear");

	property p_commit_copies;
		s_commit_write ##1 commit_q && !soft_q |=> mp_act_q == $past(mp_buf_q);
	endproperty
	a_commit_copies: assert property (p_commit_copies) else $error("active copy not updated");

	property p_active_waits;
		!commit_q && !soft_q |=> $stable(mp_act_q);
	endproperty
	a_active_waits: assert property (p_active_waits) else $error("active changed without commit");

	property p_missing_reads_zero;
		reg_rd && (reg_addr == ADDR_RSVD_7 || reg_addr == ADDR_RSVD_14 || reg_addr[15:9] != 7'h00)
			|=> reg_rdata == READ_ZERO;
	endproperty
	a_missing_reads_zero: assert property (p_missing_reads_zero) else $error("missing register read nonzero");

	property p_unlock_write;
		wd.wr_pulse && wd.wr_class == CCR_WD_UNLOCK |=> !lock_report [*1] ##0 wd.hold[0];
	endproperty
	a_unlock_write: assert property (p_unlock_write) else $error("unlock write kept lock");

	property p_wd_release;
		wd.hold[0] && commit_q && !wd.wr_pulse |=> !wd.hold[0] && wd.restart[0];
	endproperty
	a_wd_release: assert property (p_wd_release) else $error("lock hold not released at commit");

	property p_soft_reset;
		wr_cfg_a && soft_req && !soft_q |=> soft_q ##1 cfg_a_q == CFG_A_RST && mp_act_q == MULTIPIN_RST;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");
endmodule

// ==== ccr_pkg.sv ====
// Constants shared by the clock chip configuration register bank.
package ccr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// Register byte addresses.
	localparam logic [15:0] ADDR_CFG_A = 16'h0000;
	localparam logic [15:0] ADDR_CFG_B = 16'h0001;
	localparam logic [15:0] ADDR_RSVD_2 = 16'h0002;
	localparam logic [15:0] ADDR_CHIP_KIND = 16'h0003;
	localparam logic [15:0] ADDR_SERIAL_LO = 16'h0004;
	localparam logic [15:0] ADDR_SERIAL_HI = 16'h0005;
	localparam logic [15:0] ADDR_VERSION = 16'h0006;
	localparam logic [15:0] ADDR_RSVD_7 = 16'h0007;
	localparam logic [15:0] ADDR_RSVD_10 = 16'h000a;
	localparam logic [15:0] ADDR_PORT_VER = 16'h000b;
	localparam logic [15:0] ADDR_MAKER_LO = 16'h000c;
	localparam logic [15:0] ADDR_MAKER_HI = 16'h000d;
	localparam logic [15:0] ADDR_RSVD_14 = 16'h000e;
	localparam logic [15:0] ADDR_COMMIT = 16'h000f;
	localparam logic [15:0] ADDR_MULTIPIN = 16'h0100;
	// Field positions.
	localparam int CFGA_SOFT_HI = 7;
	localparam int CFGA_LSB_HI = 6;
	localparam int CFGA_ASC_HI = 5;
	localparam int CFGA_ASC_LO = 2;
	localparam int CFGA_LSB_LO = 1;
	localparam int CFGA_SOFT_LO = 0;
	localparam int CFGB_READ_BUF = 5;
	localparam int CFGB_KEEP_MAP = 4;
	localparam int COMMIT_BIT = 0;
	// Reset values and the commit code.
	localparam logic [7:0] CFG_A_RST = 8'h00;
	localparam logic [7:0] CFG_B_RST = 8'h00;
	localparam logic [7:0] MULTIPIN_RST = 8'h00;
	localparam logic [7:0] COMMIT_CODE = 8'h01;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Write-detect classes.
	localparam int WD_N = 7;
	typedef enum logic [2:0] {
		CCR_WD_NONE = 3'h0,
		CCR_WD_UNLOCK = 3'h1,
		CCR_WD_REF_FAULT = 3'h2,
		CCR_WD_LOCK_DROP = 3'h3,
		CCR_WD_WATCHDOG = 3'h4,
		CCR_WD_SYSCLK_TIMER = 3'h5,
		CCR_WD_FUNC_SWAP = 3'h6,
		CCR_WD_DEMAP = 3'h7
	} ccr_wd_class_t;
endpackage

// ==== ccr_wd_if.sv ====
// Link between the register bank and its write-detect logic.
`timescale 1ns/100ps
interface ccr_wd_if;
	import ccr_pkg::*;
	logic wr_pulse;
	ccr_wd_class_t wr_class;
	logic commit;
	logic [WD_N-1:0] hold;
	logic [WD_N-1:0] restart;
	modport bank (output wr_pulse, output wr_class, output commit, input hold, input restart);
	modport detect (input wr_pulse, input wr_class, input commit, output hold, output restart);
endinterface

// ==== ccr_write_detect.sv ====
// Write-detect side effects: one hold flag and one restart pulse per class.
`timescale 1ns/100ps
module ccr_write_detect (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Link to the bank.
	ccr_wd_if.detect wd
);
	import ccr_pkg::*;
	logic [WD_N-1:0] hold_q;
	logic [WD_N-1:0] hold_d;
	logic [WD_N-1:0] restart_q;
	logic [WD_N-1:0] restart_d;
	logic [WD_N-1:0] set_hit;

	genvar gi;
	generate
		for (gi = 0; gi < WD_N; gi++) begin : g_class
			// Class code gi+1 selects flag gi; a write in the commit cycle keeps the flag set.
			assign set_hit[gi] = wd.wr_pulse && (wd.wr_class == ccr_wd_class_t'(3'(gi + 1)));
			assign hold_d[gi] = set_hit[gi] | (hold_q[gi] & ~wd.commit);
			assign restart_d[gi] = wd.commit & hold_q[gi] & ~set_hit[gi];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_q <= '0;
			restart_q <= '0;
		end else begin
			hold_q <= hold_d;
			restart_q <= restart_d;
		end
	end

	assign wd.hold = hold_q;
	assign wd.restart = restart_q;
endmodule

// ==== ccr_host_model.sv ====
// Host controller model that drives the byte register port of the bank.
`timescale 1ns/100ps
module ccr_host_model (
	// Clock.
	input wire logic clk,
	// Byte register port.
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	import ccr_pkg::*;
	initial begin
		reg_addr = 16'hffff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'hff;
	end
	// Callers pass reserved fields as zero, their default; idle lines show the inverse of the last value.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk);
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end
		end
	endtask
endmodule

// ==== test_clock_chip_config_register_bank.sv ====
// Self-checking testbench for the configuration register bank.
`timescale 1ns/100ps
module test_clock_chip_config_register_bank;
	import ccr_pkg::*;
	localparam logic [3:0] KIND = 4'h6; // Arbitrary value.
	localparam logic [11:0] SER = 12'hab3; // Arbitrary value.
	localparam logic [7:0] VER = 8'h2c; // Arbitrary value.
	localparam logic [15:0] MAKER = 16'h7e19; // Arbitrary value.
	logic clk, rst_n, lock_raw, reg_wr, reg_rd, reg_rvalid, lsb_first, addr_ascend;
	logic keep_map_reset, commit_pulse, lock_report;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, multipin_drive_modes, v;
	logic [6:0] wd_hold, wd_restart;
	int errors = 0;
	int checks_done = 0;
	int n_commit = 0;
	int n_keep = 0;
	int n_restart = 0;
	bit ok;
	ccr_regbank #(.CHIP_KIND(KIND), .PART_SERIAL(SER), .PART_VERSION(VER), .MAKER_CODE(MAKER),
		.MULTIPIN_WD(CCR_WD_UNLOCK)) ccr_regbank_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .lsb_first(lsb_first), .addr_ascend(addr_ascend),
		.keep_map_reset(keep_map_reset), .commit_pulse(commit_pulse),
		.multipin_drive_modes(multipin_drive_modes), .lock_raw(lock_raw), .lock_report(lock_report),
		.wd_hold(wd_hold), .wd_restart(wd_restart));
	ccr_host_model ccr_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Pulses last one cycle, so they are counted as they pass.
	always @(posedge clk) begin
		if (commit_pulse === 1'b1) n_commit++;
		if (keep_map_reset === 1'b1) n_keep++;
		if (wd_restart[0] === 1'b1) n_restart++;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		ccr_host_model_i.rd(a, v, ok);
		chk($sformatf("rvalid %h", a), 8'h01, {7'h00, ok});
		chk($sformatf("rdata %h", a), exp, v);
	endtask
	task automatic wrap_up;
		if (errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		rst_n <= 1'b0;
		lock_raw <= 1'b1;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk(ADDR_CFG_A, CFG_A_RST);
		rchk(ADDR_CFG_B, CFG_B_RST);
		rchk(ADDR_MULTIPIN, MULTIPIN_RST);
		chk("lock_report", 8'h01, {7'h00, lock_report});
		@(posedge clk);
		lock_raw <= 1'b0;
		@(posedge clk);
		chk("lock_report", 8'h00, {7'h00, lock_report});
		lock_raw <= 1'b1;
		ccr_host_model_i.wr(ADDR_CHIP_KIND, 8'h0f);
		ccr_host_model_i.wr(16'h0200, 8'hff);
		rchk(ADDR_CHIP_KIND, {4'h0, KIND});
		rchk(ADDR_SERIAL_LO, {SER[3:0], 4'h0});
		rchk(ADDR_SERIAL_HI, SER[11:4]);
		rchk(ADDR_VERSION, VER);
		rchk(ADDR_PORT_VER, 8'h00);
		rchk(ADDR_MAKER_LO, MAKER[7:0]);
		rchk(ADDR_MAKER_HI, MAKER[15:8]);
		rchk(16'h0200, READ_ZERO);
		rchk(ADDR_RSVD_7, READ_ZERO);
		rchk(ADDR_RSVD_14, READ_ZERO);
		ccr_host_model_i.wr(ADDR_CFG_A, 8'h40);
		rchk(ADDR_CFG_A, 8'h42);
		chk("lsb_first", 8'h01, {7'h00, lsb_first});
		ccr_host_model_i.wr(ADDR_CFG_A, 8'h04);
		rchk(ADDR_CFG_A, 8'h24);
		chk("addr_ascend", 8'h01, {7'h00, addr_ascend});
		chk("lsb_first", 8'h00, {7'h00, lsb_first});
		ccr_host_model_i.wr(ADDR_MULTIPIN, 8'ha5);
		rchk(ADDR_MULTIPIN, MULTIPIN_RST);
		chk("lock_report", 8'h00, {7'h00, lock_report});
		chk("wd_hold", 8'h01, {1'b0, wd_hold});
		ccr_host_model_i.wr(ADDR_CFG_B, 8'h20);
		rchk(ADDR_CFG_B, 8'h20);
		rchk(ADDR_MULTIPIN, 8'ha5);
		ccr_host_model_i.wr(ADDR_COMMIT, 8'h00);
		repeat (3) @(posedge clk);
		chk("multipin", MULTIPIN_RST, multipin_drive_modes);
		chk("commit count", 8'h00, n_commit[7:0]);
		ccr_host_model_i.wr(ADDR_COMMIT, COMMIT_CODE);
		repeat (3) @(posedge clk);
		chk("multipin", 8'ha5, multipin_drive_modes);
		chk("commit count", 8'h01, n_commit[7:0]);
		chk("restart count", 8'h01, n_restart[7:0]);
		chk("wd_hold", 8'h00, {1'b0, wd_hold});
		chk("lock_report", 8'h01, {7'h00, lock_report});
		rchk(ADDR_COMMIT, 8'h00);
		ccr_host_model_i.wr(ADDR_CFG_B, 8'h10);
		rchk(ADDR_CFG_B, 8'h00);
		chk("keep count", 8'h01, n_keep[7:0]);
		ccr_host_model_i.wr(ADDR_CFG_A, 8'h81);
		repeat (3) @(posedge clk);
		chk("multipin", MULTIPIN_RST, multipin_drive_modes);
		rchk(ADDR_CFG_A, CFG_A_RST);
		chk("addr_ascend", 8'h00, {7'h00, addr_ascend});
		wrap_up;
	end
endmodule
